// ===== src/usch_defines.vh
// Purpose: constants for the synchronous link controller (usch)
// Assumes: classic Wishbone slave with 32-bit data and byte addresses
// Notes: one aligned word per register, unused bits read as zero
`ifndef USCH_DEFINES_VH
`define USCH_DEFINES_VH

`define USCH_ADR_CTRL 8'h00
`define USCH_ADR_BAUD 8'h04
`define USCH_ADR_TX 8'h08
`define USCH_ADR_RX 8'h0c
`define USCH_ADR_STAT 8'h10

`define USCH_CTRL_EN 0
`define USCH_CTRL_MASTER 1
`define USCH_CTRL_INV 2
`define USCH_CTRL_PHASE 3
`define USCH_CTRL_OD 4
`define USCH_CTRL_LSB 5
`define USCH_CTRL_W 6

`define USCH_STAT_BUSY 0
`define USCH_STAT_DONE 1

`define USCH_CTRL_RST 6'h00
`define USCH_BAUD_RST 16'h0100
`define USCH_INT_HI 15
`define USCH_INT_LO 6

// half period floor in mclk cycles; covers our own round trip of three
// cycles and gives the far end at least two samples per phase
`define USCH_MIN_HALF 10'h004
`define USCH_EDGES 5'h10
// mclk cycles without a far clock edge before a slave frame is dropped
`define USCH_IDLE_MAX 8'hc0

`endif

// ===== src/usch_sync2.v
// Purpose: two flip-flop synchroniser for one pin level
// Assumes: input may change at any time relative to mclk
// Notes: first stage is read only by the second stage
`timescale 1ns/100ps
module usch_sync2 #(
	parameter RST_VAL = 1'b0
) (
	input wire mclk,
	input wire rst,
	input wire d,
	output reg q
);
	reg meta;

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			meta <= RST_VAL;
			q <= RST_VAL;
		end else begin
			meta <= d;
			q <= meta;
		end
	end
endmodule

// ===== src/usch_host.v
// Purpose: remote synchronous serial partner of a serial port clock block
// Assumes: mclk 200 MHz, rst asynchronous active high, Wishbone classic
// Notes: either makes the transfer clock or follows the device's clock
`timescale 1ns/100ps
`include "usch_defines.vh"
module usch_host (
	input wire mclk,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [7:0] wb_adr_i,
	input wire [3:0] wb_sel_i,
	input wire [31:0] wb_dat_i,
	output reg [31:0] wb_dat_o,
	output reg wb_ack_o,
	input wire transfer_clock_pin_i,
	output reg transfer_clock_pin_o,
	output reg transfer_clock_pin_oe,
	input wire rxd_i,
	output reg txd_o,
	output reg txd_oe
);
	localparam ST_IDLE = 1'b0;
	localparam ST_RUN = 1'b1;

	reg [`USCH_CTRL_W-1:0] ctrl;
	reg [15:0] baud;
	reg [7:0] tx_sh;
	reg [7:0] rx_sh;
	reg [7:0] rx_data;
	reg done;
	reg state;
	reg [4:0] edge_cnt;
	reg [9:0] half_cnt;
	reg clk_gen;
	reg txd_val;
	reg xck_prev;
	reg [7:0] idle_cnt;
	wire xck_s;
	wire rxd_s;
	wire en;
	wire master;
	wire inv;
	wire phase;
	wire od;
	wire lsb;
	wire busy;
	wire wb_req;
	wire wr;
	wire [9:0] half_raw;
	wire [9:0] half;
	wire gen_tick;
	wire edge_any;
	wire edge_lead;
	wire edge_trail;
	wire do_sample;
	wire do_setup;
	wire tx_start;
	wire done_clr;
	reg [7:0] tx_load;
	reg [7:0] rx_out;
	integer i;

	assign en = ctrl[`USCH_CTRL_EN];
	assign master = ctrl[`USCH_CTRL_MASTER];
	assign inv = ctrl[`USCH_CTRL_INV];
	assign phase = ctrl[`USCH_CTRL_PHASE];
	assign od = ctrl[`USCH_CTRL_OD];
	assign lsb = ctrl[`USCH_CTRL_LSB];
	assign busy = (state == ST_RUN);

	usch_sync2 #(.RST_VAL(1'b0)) u_sync_xck (
		.mclk(mclk),
		.rst(rst),
		.d(transfer_clock_pin_i),
		.q(xck_s)
	);

	usch_sync2 #(.RST_VAL(1'b1)) u_sync_rxd (
		.mclk(mclk),
		.rst(rst),
		.d(rxd_i),
		.q(rxd_s)
	);

	assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr = wb_req & wb_we_i;
	assign tx_start = wr & (wb_adr_i == `USCH_ADR_TX) & wb_sel_i[0] &
		en & ~busy;
	assign done_clr = wr & (wb_adr_i == `USCH_ADR_STAT) & wb_sel_i[0] &
		wb_dat_i[`USCH_STAT_DONE];

	// only the integer field sets a synchronous rate; fraction ignored
	assign half_raw = baud[`USCH_INT_HI:`USCH_INT_LO];
	// the pin register plus the rxd synchroniser put our view of the data
	// three cycles behind the pin, so a shorter phase would take a stale bit
	assign half = (half_raw < `USCH_MIN_HALF) ? `USCH_MIN_HALF :
		half_raw;
	assign gen_tick = busy & master & (half_cnt == 10'h001);

	// edges come from our own divider or from the far clock, never both
	assign edge_any = master ? gen_tick :
		(busy & (xck_s != xck_prev));
	assign edge_lead = edge_any & (master ? (clk_gen == inv) :
		(xck_prev == inv));
	assign edge_trail = edge_any & ~edge_lead;
	// far clock and rxd go through equal synchronisers, so in slave mode a
	// sample lines up with the edge that called for it
	assign do_sample = phase ? edge_trail : edge_lead;
	assign do_setup = phase ? edge_lead : edge_trail;

	always @* begin
		tx_load = wb_dat_i[7:0];
		rx_out = rx_data;
		for (i = 0; i < 8; i = i + 1) begin
			if (lsb) begin
				tx_load[i] = wb_dat_i[7-i];
				rx_out[i] = rx_data[7-i];
			end
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h00000000;
			// unmapped reads fall through and return zero
			if (wb_req & ~wb_we_i) begin
				if (wb_adr_i == `USCH_ADR_CTRL) begin
					wb_dat_o[`USCH_CTRL_W-1:0] <= ctrl;
				end else if (wb_adr_i == `USCH_ADR_BAUD) begin
					wb_dat_o[15:0] <= baud;
				end else if (wb_adr_i == `USCH_ADR_RX) begin
					wb_dat_o[7:0] <= rx_out;
				end else if (wb_adr_i == `USCH_ADR_STAT) begin
					wb_dat_o[`USCH_STAT_BUSY] <= busy;
					wb_dat_o[`USCH_STAT_DONE] <= done;
				end
			end
		end
	end

	// settings are frozen while a frame runs so both ends stay aligned
	// no interrupt leaves this block, so setup writes run undisturbed
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			ctrl <= `USCH_CTRL_RST;
			baud <= `USCH_BAUD_RST;
		end else if (wr & ~busy) begin
			if (wb_adr_i == `USCH_ADR_CTRL) begin
				if (wb_sel_i[0]) begin
					ctrl <= wb_dat_i[`USCH_CTRL_W-1:0];
				end
			end else if (wb_adr_i == `USCH_ADR_BAUD) begin
				if (wb_sel_i[0]) begin
					baud[7:0] <= wb_dat_i[7:0];
				end
				if (wb_sel_i[1]) begin
					baud[15:8] <= wb_dat_i[15:8];
				end
			end
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			state <= ST_IDLE;
			edge_cnt <= 5'h00;
			half_cnt <= 10'h000;
			clk_gen <= 1'b0;
			tx_sh <= 8'h00;
			rx_sh <= 8'h00;
			rx_data <= 8'h00;
			txd_val <= 1'b1;
			done <= 1'b0;
			xck_prev <= 1'b0;
			idle_cnt <= 8'h00;
		end else begin
			xck_prev <= xck_s;
			if (done_clr) begin
				done <= 1'b0;
			end
			case (state)
			ST_IDLE: begin
				clk_gen <= inv;
				half_cnt <= half;
				idle_cnt <= 8'h00;
				txd_val <= 1'b1;
				if (tx_start) begin
					state <= ST_RUN;
					edge_cnt <= 5'h00;
					tx_sh <= tx_load;
					if (!phase) begin
						txd_val <= tx_load[7];
					end
				end
			end
			ST_RUN: begin
				if (master) begin
					if (gen_tick) begin
						half_cnt <= half;
						clk_gen <= ~clk_gen;
					end else begin
						half_cnt <= half_cnt - 10'h001;
					end
				end
				// a far clock that stops mid-frame would leave busy set and
				// settings frozen; the cost is a floor on the far clock rate
				if (!master) begin
					if (edge_any) begin
						idle_cnt <= 8'h00;
					end else if (idle_cnt == `USCH_IDLE_MAX) begin
						state <= ST_IDLE;
					end else begin
						idle_cnt <= idle_cnt + 8'h01;
					end
				end
				if (do_sample) begin
					rx_sh <= {rx_sh[6:0], rxd_s};
				end
				if (do_setup) begin
					if (phase) begin
						txd_val <= tx_sh[7];
						tx_sh <= {tx_sh[6:0], 1'b1};
					end else begin
						txd_val <= tx_sh[6];
						tx_sh <= {tx_sh[6:0], 1'b1};
					end
				end
				if (edge_any) begin
					edge_cnt <= edge_cnt + 5'h01;
					// the sixteenth edge closes the frame; a last sample may land
					if (edge_cnt == `USCH_EDGES - 5'h01) begin
						state <= ST_IDLE;
						done <= 1'b1;
						if (do_sample) begin
							rx_data <= {rx_sh[6:0], rxd_s};
						end else begin
							rx_data <= rx_sh;
						end
					end
				end
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// pin outputs registered; data line idles high, clock at idle level
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			transfer_clock_pin_o <= 1'b0;
			transfer_clock_pin_oe <= 1'b0;
			txd_o <= 1'b1;
			txd_oe <= 1'b0;
		end else begin
			transfer_clock_pin_o <= busy ? clk_gen : inv;
			transfer_clock_pin_oe <= en & master;
			// open drain only ever pulls low; the pull-up makes the high level
			if (od) begin
				txd_o <= 1'b0;
				txd_oe <= en & ~txd_val;
			end else begin
				txd_o <= txd_val;
				txd_oe <= en;
			end
		end
	end
endmodule

// ===== verification/usch_sva.sv
// Purpose: bus and pin checks for usch_host
// Assumes: one mclk domain
// Notes: sees design ports only
`timescale 1ns/100ps
module usch_sva (
	input wire mclk,
	input wire rst,
	input wire wb_cyc_i,
	input wire wb_stb_i,
	input wire wb_we_i,
	input wire [31:0] wb_dat_o,
	input wire wb_ack_o,
	input wire transfer_clock_pin_o,
	input wire transfer_clock_pin_oe,
	input wire txd_o,
	input wire txd_oe
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held");
	ack_timing_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("ack late");
	ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
		else $error("ack without request");
	dat_idle_a: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
		else $error("read data outside ack");
	dat_write_a: assert property (wb_ack_o && $past(wb_we_i) |-> wb_dat_o == 32'h0)
		else $error("read data on write");
	half_min_a: assert property (transfer_clock_pin_oe &&
		$changed(transfer_clock_pin_o) |=> $stable(transfer_clock_pin_o)[*3])
		else $error("clock phase too short");
	oe_cause_a: assert property ($changed(transfer_clock_pin_oe) |->
		wb_ack_o || $past(wb_ack_o) || $past(wb_ack_o, 2))
		else $error("clock enable moved alone");
	reset_vals_a: assert property ($fell(rst) |-> !wb_ack_o && txd_o &&
		!txd_oe && !transfer_clock_pin_oe) else $error("bad reset value");
endmodule
bind usch_host usch_sva chk (.mclk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
	.wb_dat_o, .wb_ack_o, .transfer_clock_pin_o, .transfer_clock_pin_oe,
	.txd_o, .txd_oe);

// ===== verification/usch_dev.sv
// Purpose: remote device on the link, following or making the pin clock
// Assumes: eight bit frames, msb first; own clock of 8 ns period
// Notes: edges picked by inversion and phase; clock made only after go
`timescale 1ns/100ps
module usch_dev (
	input wire clk_line,
	input wire din,
	input wire inv,
	input wire phase,
	input wire load,
	input wire go,
	input wire [15:0] baud,
	input wire [7:0] tx_byte,
	output wire dout,
	output reg gen_clk = 1'b0,
	output reg [7:0] rx_byte
);
	reg dclk = 1'b0;
	reg [8:0] sh = 9'h1ff;
	reg [9:0] cnt = 10'h000;
	reg [5:0] acc = 6'h00;
	reg [4:0] left = 5'h00;
	wire [6:0] acc_next = {1'b0, acc} + {1'b0, baud[5:0]};
	wire s = clk_line ^ inv ^ phase;
	assign dout = sh[8];
	initial forever #4 dclk = ~dclk;
	// master end: own generator, integer reload per phase, and a carry out
	// of the fraction stretches that phase by one cycle; still between frames
	always @(posedge dclk or posedge go) begin
		if (go) begin
			cnt <= baud[15:6];
			acc <= 6'h00;
			left <= 5'h10;
			gen_clk <= inv;
		end else if (left != 5'h00) begin
			if (cnt > 10'h001) begin
				cnt <= cnt - 10'h001;
			end else begin
				cnt <= baud[15:6] + {9'h000, acc_next[6]};
				acc <= acc_next[5:0];
				gen_clk <= ~gen_clk;
				left <= left - 5'h01;
			end
		end
	end
	always @(posedge s) begin
		rx_byte <= {rx_byte[6:0], din};
	end
	// phase 1 holds an idle one so the leading edge shows the first bit
	always @(negedge s or posedge load) begin
		if (load)
			sh <= phase ? {1'b1, tx_byte} : {tx_byte, 1'b1};
		else
			sh <= {sh[7:0], 1'b1};
	end
endmodule

// ===== verification/usch_host_tb.sv
// Purpose: bench for usch_host
// Assumes: half period of four mclk cycles
// Notes: in slave mode the partner divides its own clock for the link
`timescale 1ns/100ps
`include "usch_defines.vh"
module usch_host_tb;
	reg mclk = 1'b0;
	reg rst = 1'b1;
	reg cyc = 1'b0;
	reg stb = 1'b0;
	reg we = 1'b0;
	reg [7:0] adr = 8'h00;
	reg [31:0] dat = 32'h0;
	reg go = 1'b0;
	reg [7:0] dtx = 8'h00;
	reg [7:0] hb = 8'h00;
	reg load = 1'b0;
	reg inv = 1'b0;
	reg ph = 1'b0;
	reg [31:0] r;
	wire [31:0] q;
	wire [7:0] drb;
	wire gclk;
	wire ack, co, coe, txo, txoe, drx;
	integer err_total = 0;
	integer checks_done = 0;
	integer i, n, k;
	// a released data line sits at its pull-up; the clock pin follows its driver
	wire clk_line = coe ? co : gclk;
	wire tx_line = txoe ? txo : 1'b1;
	usch_host uut (.mclk(mclk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat),
		.wb_dat_o(q), .wb_ack_o(ack), .transfer_clock_pin_i(clk_line),
		.transfer_clock_pin_o(co), .transfer_clock_pin_oe(coe),
		.rxd_i(drx), .txd_o(txo), .txd_oe(txoe));
	// partner half period is three of its own 8 ns cycles, fraction zero
	usch_dev dev (.clk_line(clk_line), .din(tx_line), .inv(inv), .phase(ph),
		.load(load), .go(go), .baud(16'h00c0), .tx_byte(dtx), .dout(drx),
		.gen_clk(gclk), .rx_byte(drb));
	initial forever #2.5 mclk = ~mclk;
	task stop_test;
		begin
			$display("checks %0d errors %0d", checks_done, err_total);
			if (err_total == 0 && checks_done > 0)
				$display("Result: passed");
			else
				$display("Result: failed");
			$finish;
		end
	endtask
	task chk(input [31:0] s, input [31:0] e);
		begin
			checks_done = checks_done + 1;
			if (s !== e) begin
				err_total = err_total + 1;
				$display("[ERR] %0t seen %h exp %h", $time, s, e);
			end
		end
	endtask
	// lsb first order seen from the msb first partner
	function [7:0] rev8(input [7:0] v);
		integer j;
		begin
			for (j = 0; j < 8; j = j + 1)
				rev8[j] = v[7 - j];
		end
	endfunction
	task wb(input [7:0] a, input w, input [31:0] d);
		begin
			@(posedge mclk);
			cyc <= 1'b1;
			stb <= 1'b1;
			adr <= a;
			we <= w;
			dat <= d;
			n = 0;
			do begin
				@(posedge mclk);
				n = n + 1;
			end while (ack !== 1'b1 && n < 20);
			r = q;
			cyc <= 1'b0;
			stb <= 1'b0;
			if (ack !== 1'b1) begin
				err_total = err_total + 1;
				stop_test;
			end
		end
	endtask
	task rd(input [7:0] a, input [31:0] e);
		begin
			wb(a, 1'b0, 32'h0);
			chk(r, e);
		end
	endtask
	task idle;
		begin
			k = 0;
			r = 32'h1;
			while (r[0] !== 1'b0 && k < 100) begin
				wb(`USCH_ADR_STAT, 1'b0, 32'h0);
				k = k + 1;
			end
			if (r[0] !== 1'b0) begin
				err_total = err_total + 1;
				stop_test;
			end
		end
	endtask
	task start(input [7:0] b);
		begin
			repeat (2) @(posedge mclk);
			load <= 1'b1;
			@(posedge mclk);
			load <= 1'b0;
			hb = b;
			wb(`USCH_ADR_TX, 1'b1, {24'h0, b});
		end
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst <= 1'b0;
		rd(`USCH_ADR_CTRL, 32'h0);
		rd(`USCH_ADR_BAUD, 32'h0100);
		wb(8'h14, 1'b1, 32'hff);
		rd(8'h14, 32'h0);
		for (i = 0; i < 5; i = i + 1) begin
			inv <= i[1];
			ph <= i[0];
			dtx <= 8'h5a ^ i[7:0];
			wb(`USCH_ADR_BAUD, 1'b1, 32'h0080);
			wb(`USCH_ADR_CTRL, 1'b1, i < 4 ? {i[0], i[1], 2'b11} : 32'h33);
			start(8'hc3 ^ i[7:0]);
			rd(`USCH_ADR_STAT, 32'h1);
			wb(`USCH_ADR_BAUD, 1'b1, 32'h00c0);
			idle;
			chk(r, 32'h2);
			rd(`USCH_ADR_RX, {24'h0, (i == 4) ? rev8(dtx) : dtx});
			chk(drb, (i == 4) ? rev8(hb) : hb);
			rd(`USCH_ADR_BAUD, 32'h0080);
			wb(`USCH_ADR_STAT, 1'b1, 32'h2);
		end
		wb(`USCH_ADR_CTRL, 1'b1, 32'h1);
		repeat (3) @(posedge mclk);
		chk(coe, 1'b0);
		start(8'h96);
		go <= 1'b1;
		@(posedge mclk);
		go <= 1'b0;
		idle;
		chk(r, 32'h2);
		rd(`USCH_ADR_RX, {24'h0, dtx});
		chk(drb, 8'h96);
		wb(`USCH_ADR_STAT, 1'b1, 32'h2);
		// no far clock at all: the frame must be dropped without done
		start(8'h3c);
		idle;
		chk(r, 32'h0);
		stop_test;
	end
endmodule
